// ===== src/tm_pkg.sv
// Contract
// - Remote offsets are 10-bit signed quarter degrees
// - First offset high at 0x11, fraction 0x12
// - Second offset high at 0x34, fraction 0x35
// - Setup bit 3 steers offset access to second
// - Low byte holds two top bits; sign in high
// - Offset spans minus 128 to plus 127.75
// - Stored offset added to every remote result
// - Offsets reset to zero; results also reset to zero
// - One-shot write in standby runs one conversion
// - One-shot data byte ignored, strobe alone triggers
// - Bits 3:1 pick one to four faults
// - Fault filter at 0x22, resets to 0x01
// - Bits 7 and 6 enable bus timeouts
// - Some registers use separate read/write addresses
// - Bank bit steers shared addresses 01 to 19
// - Second channel direct at 30 to 39
// - Limit, hysteresis and rate reset values
package tm_pkg;

  // ----------------------------------------------------------------
  // Read addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] RA_LOCAL_RES = 8'h00;
  localparam logic [7:0] RA_REM_RES_H = 8'h01;
  localparam logic [7:0] RA_FLAGS1 = 8'h02;
  localparam logic [7:0] RA_SETUP1 = 8'h03;
  localparam logic [7:0] RA_RATE = 8'h04;
  localparam logic [7:0] RA_LOC_UP = 8'h05;
  localparam logic [7:0] RA_LOC_LO = 8'h06;
  localparam logic [7:0] RA_REM_UP_H = 8'h07;
  localparam logic [7:0] RA_REM_LO_H = 8'h08;
  localparam logic [7:0] RA_REM_RES_L = 8'h10;
  localparam logic [7:0] RA_FLAGS2 = 8'h23;
  localparam logic [7:0] RA_R2_RES_H = 8'h30;
  localparam logic [7:0] RA_R2_RES_L = 8'h33;
  localparam logic [7:0] RA_MAKER = 8'hFE;
  localparam logic [7:0] RA_REV = 8'hFF;
  // ----------------------------------------------------------------
  // Write-only addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] WA_SETUP1 = 8'h09;
  localparam logic [7:0] WA_RATE = 8'h0A;
  localparam logic [7:0] WA_LOC_UP = 8'h0B;
  localparam logic [7:0] WA_LOC_LO = 8'h0C;
  localparam logic [7:0] WA_REM_UP_H = 8'h0D;
  localparam logic [7:0] WA_REM_LO_H = 8'h0E;
  localparam logic [7:0] WA_ONE_SHOT = 8'h0F;
  // ----------------------------------------------------------------
  // Shared read/write addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CAL_H = 8'h11;
  localparam logic [7:0] A_CAL_L = 8'h12;
  localparam logic [7:0] A_REM_UP_L = 8'h13;
  localparam logic [7:0] A_REM_LO_L = 8'h14;
  localparam logic [7:0] A_REM_HOT = 8'h19;
  localparam logic [7:0] A_LOC_HOT = 8'h20;
  localparam logic [7:0] A_HYST = 8'h21;
  localparam logic [7:0] A_FILTER = 8'h22;
  localparam logic [7:0] A_SETUP2 = 8'h24;
  localparam logic [7:0] A_R2_UP_H = 8'h31;
  localparam logic [7:0] A_R2_LO_H = 8'h32;
  localparam logic [7:0] A_R2_CAL_H = 8'h34;
  localparam logic [7:0] A_R2_CAL_L = 8'h35;
  localparam logic [7:0] A_R2_UP_L = 8'h36;
  localparam logic [7:0] A_R2_LO_L = 8'h37;
  localparam logic [7:0] A_R2_HOT = 8'h39;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int BANK_BIT = 3;
  localparam int SCL_TO_BIT = 7;
  localparam int SDA_TO_BIT = 6;
  localparam int MASK_BIT = 5;
  localparam logic [7:0] RST_SETUP = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h07;
  localparam logic [7:0] RST_HIGH = 8'h55;
  localparam logic [7:0] RST_LOW = 8'h00;
  localparam logic [7:0] RST_HYST = 8'h0A;
  localparam logic [7:0] RST_FILTER = 8'h01;
  localparam logic [7:0] RST_CAL_H = 8'h00;
  localparam logic [1:0] RST_CAL_L = 2'h0;
  localparam logic [9:0] RST_RESULT = 10'h000;
  localparam logic [1:0] CH_LOCAL = 2'h0;
  localparam logic [1:0] CH_R1 = 2'h1;
  localparam logic [1:0] CH_R2 = 2'h2;

  // Limits of one remote channel
  typedef struct packed {
    logic [7:0] upper_h;
    logic [7:0] lower_h;
    logic [7:0] upper_l;
    logic [7:0] lower_l;
    logic [7:0] overheat;
  } tm_limits_t;

  localparam tm_limits_t LIMITS_RST = '{upper_h: RST_HIGH, lower_h: RST_LOW,
                                        upper_l: RST_LOW, lower_l: RST_LOW,
                                        overheat: RST_HIGH};

  // One raw measurement from the converter, 8.2 format
  typedef struct packed {
    logic [1:0] ch;
    logic [9:0] raw;
  } tm_meas_t;

endpackage : tm_pkg

// ===== src/tm_reg_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tm_reg_bank #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] REV_CODE = 8'h03    // Arbitrary value
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic WR_EN,
  input wire logic [7:0] WR_ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic RD_EN,
  input wire logic [7:0] RD_ADDR,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  input wire logic STANDBY,
  input wire logic MEAS_VALID,
  input wire tm_pkg::tm_meas_t MEAS,
  input wire logic [7:0] FLAGS1_IN,
  input wire logic [7:0] FLAGS2_IN,
  output logic ONE_SHOT,
  output logic [7:0] LOCAL_RESULT,
  output logic [9:0] R1_RESULT,
  output logic [9:0] R2_RESULT,
  output logic [7:0] SETUP1,
  output logic [7:0] SETUP2,
  output logic [7:0] RATE_SEL,
  output logic [7:0] LOCAL_UPPER,
  output logic [7:0] LOCAL_LOWER,
  output logic [7:0] LOCAL_OVERHEAT,
  output logic [7:0] HYSTERESIS,
  output var tm_pkg::tm_limits_t R1_LIMITS,
  output var tm_pkg::tm_limits_t R2_LIMITS,
  output logic [2:0] CONSEC_NEEDED,
  output logic SCL_TIMEOUT_EN,
  output logic SDA_TIMEOUT_EN,
  output logic ALERT_MASK
);

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [7:0] setup1_q;
  logic [7:0] setup2_q;
  logic [7:0] rate_q;
  logic [7:0] loc_up_q;
  logic [7:0] loc_lo_q;
  logic [7:0] loc_hot_q;
  logic [7:0] hyst_q;
  logic [7:0] filter_q;
  tm_pkg::tm_limits_t [1:0] lim_q;
  logic [1:0][7:0] cal_h_q;
  logic [1:0][1:0] cal_l_q;
  logic [9:0] res_q [2]; // One entry per remote channel; local result kept apart
  logic [7:0] loc_res_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic one_shot_q;
  logic [2:0] consec_q;
  logic wr;
  logic bank;

  assign wr = CE & WR_EN;
  assign bank = setup1_q[tm_pkg::BANK_BIT];

  // ------------------------------------------------------------------
  // Global setup registers
  // ------------------------------------------------------------------
  // Separate write addresses for setup1, rate and local upper/lower limits
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      setup1_q <= tm_pkg::RST_SETUP;
      setup2_q <= tm_pkg::RST_SETUP;
      rate_q <= tm_pkg::RST_RATE;
      loc_up_q <= tm_pkg::RST_HIGH;
      loc_lo_q <= tm_pkg::RST_LOW;
      loc_hot_q <= tm_pkg::RST_HIGH;
      hyst_q <= tm_pkg::RST_HYST;
      filter_q <= tm_pkg::RST_FILTER;
    end else if (wr) begin
      unique case (WR_ADDR)
        tm_pkg::WA_SETUP1: setup1_q <= WR_DATA;
        tm_pkg::A_SETUP2: setup2_q <= WR_DATA;
        tm_pkg::WA_RATE: rate_q <= WR_DATA;
        tm_pkg::WA_LOC_UP: loc_up_q <= WR_DATA;
        tm_pkg::WA_LOC_LO: loc_lo_q <= WR_DATA;
        tm_pkg::A_LOC_HOT: loc_hot_q <= WR_DATA;
        tm_pkg::A_HYST: hyst_q <= WR_DATA;
        tm_pkg::A_FILTER: filter_q <= WR_DATA;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Remote channel limits and offsets
  // ------------------------------------------------------------------
  // Shared addresses hit the channel picked by the bank bit
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      lim_q <= {tm_pkg::LIMITS_RST, tm_pkg::LIMITS_RST};
      cal_h_q <= {tm_pkg::RST_CAL_H, tm_pkg::RST_CAL_H};
      cal_l_q <= {tm_pkg::RST_CAL_L, tm_pkg::RST_CAL_L};
    end else if (wr) begin
      unique case (WR_ADDR)
        tm_pkg::WA_REM_UP_H: lim_q[bank].upper_h <= WR_DATA;
        tm_pkg::WA_REM_LO_H: lim_q[bank].lower_h <= WR_DATA;
        tm_pkg::A_REM_UP_L: lim_q[bank].upper_l <= WR_DATA;
        tm_pkg::A_REM_LO_L: lim_q[bank].lower_l <= WR_DATA;
        tm_pkg::A_REM_HOT: lim_q[bank].overheat <= WR_DATA;
        tm_pkg::A_CAL_H: cal_h_q[bank] <= WR_DATA;
        tm_pkg::A_CAL_L: cal_l_q[bank] <= WR_DATA[7:6];
        tm_pkg::A_R2_UP_H: lim_q[1].upper_h <= WR_DATA;
        tm_pkg::A_R2_LO_H: lim_q[1].lower_h <= WR_DATA;
        tm_pkg::A_R2_UP_L: lim_q[1].upper_l <= WR_DATA;
        tm_pkg::A_R2_LO_L: lim_q[1].lower_l <= WR_DATA;
        tm_pkg::A_R2_HOT: lim_q[1].overheat <= WR_DATA;
        tm_pkg::A_R2_CAL_H: cal_h_q[1] <= WR_DATA;
        tm_pkg::A_R2_CAL_L: cal_l_q[1] <= WR_DATA[7:6];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // One-shot trigger
  // ------------------------------------------------------------------
  // Only the strobe and STANDBY matter; the data byte is dropped
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      one_shot_q <= 1'b0;
    end else if (CE) begin
      one_shot_q <= WR_EN && (WR_ADDR == tm_pkg::WA_ONE_SHOT) && STANDBY;
    end
  end

  // ------------------------------------------------------------------
  // Consecutive fault count decode
  // ------------------------------------------------------------------
  // Bit 0 ignored; codes 000, 001, 011, 111 in bits 3:1 give one to four
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      consec_q <= 3'h1;
    end else if (CE) begin
      unique case (filter_q[3:1])
        3'b000: consec_q <= 3'h1;
        3'b001: consec_q <= 3'h2;
        3'b011: consec_q <= 3'h3;
        3'b111: consec_q <= 3'h4;
        default: consec_q <= 3'h1; // Undefined codes act as one
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Measurement results, offset applied to remote channels
  // ------------------------------------------------------------------
  // Local result stored without offset, top eight raw bits only
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      loc_res_q <= 8'h00;
    end else if (CE && MEAS_VALID && MEAS.ch == tm_pkg::CH_LOCAL) begin
      loc_res_q <= MEAS.raw[9:2];
    end
  end

  // Unsigned raw plus signed offset, clamped to the 10-bit range
  for (genvar i = 0; i < 2; i++) begin : g_rem
    logic [9:0] cal;
    logic [11:0] sum;
    logic [1:0] my_ch;
    assign my_ch = 2'(i + 1);
    assign cal = {cal_h_q[i], cal_l_q[i]};
    assign sum = {2'h0, MEAS.raw} + {{2{cal[9]}}, cal};
    always_ff @(posedge CLOCK) begin
      if (RST) begin
        res_q[i] <= tm_pkg::RST_RESULT;
      end else if (CE && MEAS_VALID && MEAS.ch == my_ch) begin
        if (sum[11]) begin
          res_q[i] <= 10'h000; // Below zero
        end else if (sum[10]) begin
          res_q[i] <= 10'h3FF; // Above full scale
        end else begin
          res_q[i] <= sum[9:0];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  // Data one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else if (CE) begin
      rd_valid_q <= RD_EN;
      if (RD_EN) begin
        case (RD_ADDR)
          tm_pkg::RA_LOCAL_RES: rd_data_q <= loc_res_q;
          tm_pkg::RA_REM_RES_H: rd_data_q <= res_q[bank][9:2];
          tm_pkg::RA_REM_RES_L: rd_data_q <= {res_q[bank][1:0], 6'h00};
          tm_pkg::RA_FLAGS1: rd_data_q <= FLAGS1_IN;
          tm_pkg::RA_SETUP1: rd_data_q <= setup1_q;
          tm_pkg::RA_RATE: rd_data_q <= rate_q;
          tm_pkg::RA_LOC_UP: rd_data_q <= loc_up_q;
          tm_pkg::RA_LOC_LO: rd_data_q <= loc_lo_q;
          tm_pkg::RA_REM_UP_H: rd_data_q <= lim_q[bank].upper_h;
          tm_pkg::RA_REM_LO_H: rd_data_q <= lim_q[bank].lower_h;
          tm_pkg::A_CAL_H: rd_data_q <= cal_h_q[bank];
          tm_pkg::A_CAL_L: rd_data_q <= {cal_l_q[bank], 6'h00};
          tm_pkg::A_REM_UP_L: rd_data_q <= lim_q[bank].upper_l;
          tm_pkg::A_REM_LO_L: rd_data_q <= lim_q[bank].lower_l;
          tm_pkg::A_REM_HOT: rd_data_q <= lim_q[bank].overheat;
          tm_pkg::A_LOC_HOT: rd_data_q <= loc_hot_q;
          tm_pkg::A_HYST: rd_data_q <= hyst_q;
          tm_pkg::A_FILTER: rd_data_q <= filter_q;
          tm_pkg::RA_FLAGS2: rd_data_q <= FLAGS2_IN;
          tm_pkg::A_SETUP2: rd_data_q <= setup2_q;
          tm_pkg::RA_R2_RES_H: rd_data_q <= res_q[1][9:2];
          tm_pkg::A_R2_UP_H: rd_data_q <= lim_q[1].upper_h;
          tm_pkg::A_R2_LO_H: rd_data_q <= lim_q[1].lower_h;
          tm_pkg::RA_R2_RES_L: rd_data_q <= {res_q[1][1:0], 6'h00};
          tm_pkg::A_R2_CAL_H: rd_data_q <= cal_h_q[1];
          tm_pkg::A_R2_CAL_L: rd_data_q <= {cal_l_q[1], 6'h00};
          tm_pkg::A_R2_UP_L: rd_data_q <= lim_q[1].upper_l;
          tm_pkg::A_R2_LO_L: rd_data_q <= lim_q[1].lower_l;
          tm_pkg::A_R2_HOT: rd_data_q <= lim_q[1].overheat;
          tm_pkg::RA_MAKER: rd_data_q <= MAKER_CODE;
          tm_pkg::RA_REV: rd_data_q <= REV_CODE;
          default: rd_data_q <= 8'h00;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ------------------------------------------------------------------
  assign RD_DATA = rd_data_q;
  assign RD_VALID = rd_valid_q;
  assign ONE_SHOT = one_shot_q;
  assign LOCAL_RESULT = loc_res_q;
  assign R1_RESULT = res_q[0];
  assign R2_RESULT = res_q[1];
  assign SETUP1 = setup1_q;
  assign SETUP2 = setup2_q;
  assign RATE_SEL = rate_q;
  assign LOCAL_UPPER = loc_up_q;
  assign LOCAL_LOWER = loc_lo_q;
  assign LOCAL_OVERHEAT = loc_hot_q;
  assign HYSTERESIS = hyst_q;
  assign R1_LIMITS = lim_q[0];
  assign R2_LIMITS = lim_q[1];
  assign CONSEC_NEEDED = consec_q;
  assign SCL_TIMEOUT_EN = filter_q[tm_pkg::SCL_TO_BIT];
  assign SDA_TIMEOUT_EN = filter_q[tm_pkg::SDA_TO_BIT];
  assign ALERT_MASK = filter_q[tm_pkg::MASK_BIT];

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_rd(logic [7:0] a);
    CE && RD_EN && RD_ADDR == a;
  endsequence

  sequence s_wr(logic [7:0] a);
    CE && WR_EN && WR_ADDR == a;
  endsequence

  property p_reset_vals;
    disable iff (1'b0)
    RST |=> filter_q == 8'h01 && hyst_q == 8'h0A && rate_q == 8'h07
            && lim_q[1].overheat == 8'h55 && cal_h_q == '0 && !ONE_SHOT;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_cal1_read;
    s_rd(8'h11) ##0 !bank |=> RD_DATA == $past(cal_h_q[0]);
  endproperty
  a_cal1_read: assert property (p_cal1_read) else $error("offset read wrong");

  property p_cal_bank;
    s_rd(8'h11) ##0 bank |=> RD_DATA == $past(cal_h_q[1]);
  endproperty
  a_cal_bank: assert property (p_cal_bank) else $error("bank steer wrong");

  property p_cal2_direct;
    s_rd(8'h34) |=> RD_DATA == $past(cal_h_q[1]);
  endproperty
  a_cal2_direct: assert property (p_cal2_direct) else $error("direct read wrong");

  property p_frac_low;
    s_rd(8'h12) or s_rd(8'h35) |=> RD_DATA[5:0] == 6'h00;
  endproperty
  a_frac_low: assert property (p_frac_low) else $error("fraction bits wrong");

  property p_one_shot;
    CE && WR_EN && WR_ADDR == 8'h0F && STANDBY |=> ONE_SHOT
      ##1 (!ONE_SHOT || !$past(CE) || $past(WR_EN));
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot missing");

  property p_one_shot_nostore;
    CE && WR_EN && WR_ADDR == 8'h0F |=> $stable(filter_q) && $stable(setup1_q) && $stable(cal_h_q);
  endproperty
  a_one_shot_nostore: assert property (p_one_shot_nostore) else $error("one-shot stored");

  property p_consec4;
    CE && filter_q[3:1] == 3'b111 |=> CONSEC_NEEDED == 3'h4;
  endproperty
  a_consec4: assert property (p_consec4) else $error("count decode wrong");

  property p_split_addr;
    s_wr(8'h0D) ##0 !bank |=> lim_q[0].upper_h == $past(WR_DATA);
  endproperty
  a_split_addr: assert property (p_split_addr) else $error("split address wrong");

  property p_split_read;
    s_rd(8'h07) ##0 !bank |=> RD_DATA == $past(lim_q[0].upper_h);
  endproperty
  a_split_read: assert property (p_split_read) else $error("split read wrong");

  property p_offset_add;
    CE && MEAS_VALID && MEAS.ch == 2'h1 && cal_h_q[0][7] == 1'b0 && MEAS.raw[9] == 1'b0
      |=> R1_RESULT == 10'($past(MEAS.raw) + $past({cal_h_q[0], cal_l_q[0]}));
  endproperty
  a_offset_add: assert property (p_offset_add) else $error("offset not applied");

  property p_mask;
    CE && WR_EN && WR_ADDR == 8'h22 |=> ALERT_MASK == $past(WR_DATA[5])
      && SCL_TIMEOUT_EN == $past(WR_DATA[7]);
  endproperty
  a_mask: assert property (p_mask) else $error("filter bits wrong");

  property p_ident;
    s_rd(8'hFE) |=> RD_DATA == MAKER_CODE;
  endproperty
  a_ident: assert property (p_ident) else $error("identity wrong");

endmodule : tm_reg_bank
`default_nettype wire

// ===== tb/tm_host.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Register host model
// ------------------------------------------------
module tm_host (
  input wire logic clk,
  input wire logic ce,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_en,
  output logic [7:0] rd_addr
);
  // Idle bus at time zero
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_addr = 8'h00;
  end

  // Write address and data byte driven together; held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    do @(posedge clk); while (ce !== 1'b1);
    wr_en <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask : wr

  // Pointer gets the read address, answer settled just after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    do @(posedge clk); while (ce !== 1'b1);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    #1;
    d = rd_data;
    v = rd_valid;
  endtask : rd
endmodule : tm_host
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench;
  localparam logic [7:0] MK = 8'hC3; // Arbitrary value
  localparam logic [7:0] RV = 8'h1E; // Arbitrary value
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, ce_rand = 1'b0, standby = 1'b0;
  logic wr_en, rd_en, rd_valid, meas_valid = 1'b0, one_shot, scl_to, sda_to, amask;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data, loc_res, setup1, rate_sel, hyst;
  logic [7:0] flags1 = 8'h96, flags2 = 8'h2C;
  logic [7:0] setup2, loc_up, loc_lo, loc_hot;
  logic [9:0] r1_res, r2_res;
  logic [2:0] consec;
  tm_pkg::tm_meas_t meas = '0;
  tm_pkg::tm_limits_t r1_lim, r2_lim;
  logic [7:0] mem [256];
  logic [7:0] bk [9] = '{8'h01, 8'h07, 8'h08, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19};
  logic [7:0] bd [9] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h39};
  int mismatches = 0, n_checks = 0, seed = 32'hd8d4c51d;

  // Clock and random clock enable
  always #4 clk = ~clk;
  always @(posedge clk) ce <= ce_rand ? 1'($random(seed)) : 1'b1;

  tm_reg_bank #(.MAKER_CODE(MK), .REV_CODE(RV)) uut (.CLOCK(clk), .RST(rst), .CE(ce),
    .WR_EN(wr_en), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_EN(rd_en), .RD_ADDR(rd_addr),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .STANDBY(standby), .MEAS_VALID(meas_valid),
    .MEAS(meas), .FLAGS1_IN(flags1), .FLAGS2_IN(flags2), .ONE_SHOT(one_shot),
    .LOCAL_RESULT(loc_res), .R1_RESULT(r1_res), .R2_RESULT(r2_res), .SETUP1(setup1),
    .SETUP2(setup2), .RATE_SEL(rate_sel), .LOCAL_UPPER(loc_up), .LOCAL_LOWER(loc_lo),
    .LOCAL_OVERHEAT(loc_hot),
    .HYSTERESIS(hyst), .R1_LIMITS(r1_lim), .R2_LIMITS(r2_lim), .CONSEC_NEEDED(consec),
    .SCL_TIMEOUT_EN(scl_to), .SDA_TIMEOUT_EN(sda_to), .ALERT_MASK(amask));
  tm_host host (.clk(clk), .ce(ce), .rd_data(rd_data), .rd_valid(rd_valid), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr));

  // ------------------------------------------------
  // Reference model
  // ------------------------------------------------
  // Power-on contents
  task automatic minit();
    foreach (mem[i]) mem[i] = 8'h00;
    mem[8'h04] = 8'h07;
    foreach (bd[i]) if (i == 1 || i == 8) mem[bd[i]] = 8'h55;
    mem[8'h05] = 8'h55;
    mem[8'h07] = 8'h55;
    mem[8'h19] = 8'h55;
    mem[8'h20] = 8'h55;
    mem[8'h21] = 8'h0A;
    mem[8'h22] = 8'h01;
  endtask : minit
  // Shared addresses follow the bank bit
  function automatic logic [7:0] bank(logic [7:0] a);
    foreach (bk[i]) if (mem[8'h03][3] && a == bk[i]) return bd[i];
    return a;
  endfunction : bank
  function automatic bit wok(logic [7:0] a);
    return a inside {[8'h03:8'h08], 8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h20, 8'h21,
      8'h22, 8'h24, 8'h31, 8'h32, [8'h34:8'h37], 8'h39};
  endfunction : wok
  // Write map with separate write addresses; low offset bytes keep two bits
  task automatic wr2(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] s;
    host.wr(a, d);
    s = (a inside {[8'h09:8'h0E]}) ? a - 8'h06 : a;
    s = bank(s);
    if (wok(s) && !(a inside {[8'h03:8'h08]})) mem[s] = (s inside {8'h12, 8'h35}) ? d & 8'hC0 : d;
  endtask : wr2
  function automatic logic [7:0] mrd(logic [7:0] a);
    logic [7:0] s;
    s = bank(a);
    if (s == 8'hFE) return MK;
    if (s == 8'hFF) return RV;
    if (s == 8'h02) return flags1;
    if (s == 8'h23) return flags2;
    return (wok(s) || s inside {8'h00, 8'h01, 8'h10, 8'h30, 8'h33}) ? mem[s] : 8'h00;
  endfunction : mrd
  function automatic int cn(logic [7:0] f);
    case (f[3:1])
      3'b001: return 2;
      3'b011: return 3;
      3'b111: return 4;
      default: return 1;
    endcase
  endfunction : cn

  // ------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------
  // One measurement: raw plus signed quarter-degree offset, clamped
  task automatic mea(input logic [1:0] ch, input logic [9:0] raw);
    logic [7:0] h;
    logic [9:0] off;
    int r;
    h = (ch == 2'h2) ? 8'h34 : 8'h11;
    off = {mem[h], mem[h + 8'h01][7:6]};
    r = int'(raw) + int'($signed(off));
    r = (r < 0) ? 0 : (r > 1023) ? 1023 : r;
    @(posedge clk);
    meas_valid <= 1'b1;
    meas <= '{ch: ch, raw: raw};
    do @(posedge clk); while (ce !== 1'b1);
    meas_valid <= 1'b0;
    meas <= ~meas;
    if (ch == 2'h0) mem[8'h00] = raw[9:2];
    if (ch == 2'h1 || ch == 2'h2) mem[(ch == 2'h1) ? 8'h01 : 8'h30] = 8'(r >> 2);
    if (ch == 2'h1 || ch == 2'h2) mem[(ch == 2'h1) ? 8'h10 : 8'h33] = {2'(r), 6'h00};
    do @(posedge clk); while (ce !== 1'b1);
    #1;
    `CHK("local_result", mem[8'h00], loc_res)
    `CHK("r1_result", {mem[8'h01], mem[8'h10][7:6]}, r1_res)
    `CHK("r2_result", {mem[8'h30], mem[8'h33][7:6]}, r2_res)
  endtask : mea
  task automatic check_outs();
    tm_pkg::tm_limits_t e1;
    tm_pkg::tm_limits_t e2;
    e1 = '{mem[8'h07], mem[8'h08], mem[8'h13], mem[8'h14], mem[8'h19]};
    e2 = '{mem[8'h31], mem[8'h32], mem[8'h36], mem[8'h37], mem[8'h39]};
    `CHK("r1_limits", e1, r1_lim)
    `CHK("r2_limits", e2, r2_lim)
    `CHK("setup2", mem[8'h24], setup2)
    `CHK("local_upper", mem[8'h05], loc_up)
    `CHK("local_lower", mem[8'h06], loc_lo)
    `CHK("local_overheat", mem[8'h20], loc_hot)
    `CHK("setup1", mem[8'h03], setup1)
    `CHK("rate", mem[8'h04], rate_sel)
    `CHK("r1_overheat", mem[8'h19], r1_lim.overheat)
    `CHK("r2_upper", mem[8'h31], r2_lim.upper_h)
    `CHK("hysteresis", mem[8'h21], hyst)
    `CHK("consec", cn(mem[8'h22]), consec)
    `CHK("scl_timeout", mem[8'h22][7], scl_to)
    `CHK("sda_timeout", mem[8'h22][6], sda_to)
    `CHK("alert_mask", mem[8'h22][5], amask)
  endtask : check_outs
  // Read every address and compare with the model
  task automatic sweep(input string nm);
    logic [7:0] d;
    logic v;
    for (int a = 0; a < 256; a++) begin
      host.rd(8'(a), d, v);
      `CHK("rd_valid", 1'b1, v)
      `CHK("read_data", mrd(8'(a)), d)
    end
    check_outs();
    $display("test %s done", nm);
  endtask : sweep
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    minit();
  endtask : do_reset
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // Main sequence
  initial begin
    logic [7:0] oh [4] = '{8'h80, 8'h7F, 8'hFF, 8'h01};
    logic [7:0] ol [4] = '{8'h3F, 8'hFF, 8'h40, 8'h80};
    logic [9:0] rw [4] = '{10'h3FF, 10'h3FF, 10'h000, 10'h100};
    logic [7:0] fc [5] = '{8'h01, 8'h83, 8'h47, 8'h2F, 8'hFE};
    do_reset();
    sweep("reset");
    for (int p = 0; p < 2; p++) begin
      ce_rand <= 1'b1;
      standby <= 1'($random(seed));
      repeat (150) begin
        if ($random(seed) % 4 == 0) mea(2'($random(seed)), 10'($random(seed)));
        else wr2(8'($random(seed)), 8'($random(seed)));
      end
      ce_rand <= 1'b0;
      repeat (2) @(posedge clk);
      sweep("random");
    end
    for (int i = 0; i < 4; i++) begin
      wr2(8'h09, 8'((i % 2) * 8));
      wr2(8'h11, oh[i]);
      wr2(8'h12, ol[i]);
      wr2(8'h0D, oh[i]);
      mea(2'h1, rw[i]);
      mea(2'h2, rw[i]);
    end
    sweep("offset");
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      standby <= 1'(s);
      wr2(8'h0F, 8'($random(seed)));
      #1;
      `CHK("one_shot", 1'(s), one_shot)
      @(posedge clk);
      #1;
      `CHK("one_shot_end", 1'b0, one_shot)
    end
    foreach (fc[i]) begin
      wr2(8'h22, fc[i]);
      repeat (2) @(posedge clk);
      #1;
      check_outs();
    end
    sweep("oneshot_filter");
    do_reset();
    sweep("second_reset");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
